// ==== timer16_pkg.sv ====
// Shared constants, register map and mode types for the 16-bit waveform timer
package timer16_pkg;

  // Register byte offsets on the AXI4-Lite bus
  localparam int          ADDR_W      = 6;
  localparam logic [5:0]  OFS_CTRL_A  = 6'h00;
  localparam logic [5:0]  OFS_CTRL_B  = 6'h04;
  localparam logic [5:0]  OFS_CMP_A   = 6'h08;
  localparam logic [5:0]  OFS_CMP_B   = 6'h0c;
  localparam logic [5:0]  OFS_CMP_C   = 6'h10;
  localparam logic [5:0]  OFS_CAPT    = 6'h14;
  localparam logic [5:0]  OFS_COUNT   = 6'h18;
  localparam logic [5:0]  OFS_STATUS  = 6'h1c;

  // Control A fields
  localparam int          MODE_A_LSB  = 6;
  localparam int          MODE_B_LSB  = 4;
  localparam int          MODE_C_LSB  = 2;
  localparam int          WGM_LO_LSB  = 0;
  // Second control register fields
  localparam int          WGM_HI_LSB  = 3;
  localparam int          RUN_BIT     = 0;
  localparam logic [7:0]  CTRL_B_MASK = 8'h19;
  // Status fields
  localparam int          OVF_BIT     = 0;
  localparam int          OUT_LSB     = 1;
  localparam int          DIR_BIT     = 4;

  localparam logic [7:0]  CTRL_RESET  = 8'h00;
  localparam logic [15:0] CMP_RESET   = 16'h0000;

  // Counter limits
  localparam logic [15:0] VAL_MAX     = 16'hffff;
  localparam logic [15:0] VAL_BOTTOM  = 16'h0000;
  localparam logic [15:0] TOP_8BIT    = 16'h00ff;
  localparam logic [15:0] TOP_9BIT    = 16'h01ff;
  localparam logic [15:0] TOP_10BIT   = 16'h03ff;

  localparam logic [1:0]  RESP_OKAY   = 2'b00;
  localparam logic [1:0]  RESP_SLVERR = 2'b10;

  // Waveform family
  typedef enum logic [3:0] {
    KIND_NORMAL = 4'b0001,
    KIND_CTC    = 4'b0010,
    KIND_FAST   = 4'b0100,
    KIND_DUAL   = 4'b1000
  } wave_kind_t;

  // Source of the TOP value
  typedef enum logic [2:0] {
    TOP_FIXED = 3'b001,
    TOP_CMPA  = 3'b010,
    TOP_CAPT  = 3'b100
  } top_src_t;

  // Counter point at which an event happens
  typedef enum logic [3:0] {
    AT_IMM    = 4'b0001,
    AT_TOP    = 4'b0010,
    AT_BOTTOM = 4'b0100,
    AT_MAX    = 4'b1000
  } point_t;

endpackage : timer16_pkg

// ==== timer16_mode_decode.sv ====
// Decoder from the four-bit waveform mode to counting behaviour
`timescale 1ns/10ps
module timer16_mode_decode
  import timer16_pkg::*;
(
  input  wire logic [3:0]  waveform_mode_select,
  output wave_kind_t       kind,
  output top_src_t         top_src,
  output logic [15:0]      fixed_top,
  output point_t           update_at,
  output point_t           flag_at
);

  // One entry per mode group; mode 13 falls to the default and behaves as normal
  always_comb begin
    kind      = KIND_NORMAL;
    top_src   = TOP_FIXED;
    fixed_top = VAL_MAX;
    update_at = AT_IMM;
    flag_at   = AT_MAX;
    case (waveform_mode_select)
      4'h0: begin
        kind = KIND_NORMAL;
      end
      4'h1, 4'h2, 4'h3: begin
        kind      = KIND_DUAL;
        fixed_top = (waveform_mode_select == 4'h1) ? TOP_8BIT :
                    (waveform_mode_select == 4'h2) ? TOP_9BIT : TOP_10BIT;
        update_at = AT_TOP;
        flag_at   = AT_BOTTOM;
      end
      4'h4, 4'hc: begin
        kind    = KIND_CTC;
        top_src = waveform_mode_select[3] ? TOP_CAPT : TOP_CMPA;
      end
      4'h5, 4'h6, 4'h7: begin
        kind      = KIND_FAST;
        fixed_top = (waveform_mode_select == 4'h5) ? TOP_8BIT :
                    (waveform_mode_select == 4'h6) ? TOP_9BIT : TOP_10BIT;
        update_at = AT_TOP;
        flag_at   = AT_TOP;
      end
      4'h8, 4'h9, 4'ha, 4'hb: begin
        kind      = KIND_DUAL;
        top_src   = waveform_mode_select[0] ? TOP_CMPA : TOP_CAPT;
        update_at = waveform_mode_select[1] ? AT_TOP : AT_BOTTOM;
        flag_at   = AT_BOTTOM;
      end
      4'he, 4'hf: begin
        kind      = KIND_FAST;
        top_src   = waveform_mode_select[0] ? TOP_CMPA : TOP_CAPT;
        update_at = AT_TOP;
        flag_at   = AT_TOP;
      end
      default: begin
        kind = KIND_NORMAL;
      end
    endcase
  end

endmodule : timer16_mode_decode

// ==== timer16_compare_output.sv ====
// Waveform generator for one compare output channel
`timescale 1ns/10ps
module timer16_compare_output
  import timer16_pkg::*;
#(
  parameter bit IS_CHANNEL_A = 1'b0
) (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic [1:0] output_mode,
  input  wave_kind_t      kind,
  input  wire logic       wgm3,
  input  wire logic       tick,
  input  wire logic       match,
  input  wire logic       at_top,
  input  wire logic       counting_up,
  input  wire logic       cmp_is_top,
  input  wire logic       cmp_is_bottom,
  output logic            compare_output,
  output logic            override
);

  logic wave_r;
  logic wave_nxt;
  wire  is_pwm     = (kind == KIND_FAST) || (kind == KIND_DUAL);
  wire  pwm_toggle = wgm3 && IS_CHANNEL_A;
  wire  hi_bit     = output_mode[1];
  wire  lo_bit     = output_mode[0];

  // PWM mode 01 only drives the pin on channel A with the top mode bit set
  assign override = is_pwm && (output_mode == 2'b01) ? pwm_toggle : |output_mode;

  // Next pin level; toggling works in normal and CTC, in PWM only on channel A with the top mode bit set
  always_comb begin
    wave_nxt = wave_r;
    if (tick) begin
      if (output_mode == 2'b01) begin
        if (match && (!is_pwm || pwm_toggle)) begin
          wave_nxt = ~wave_r;
        end
      end else if (hi_bit && kind == KIND_FAST) begin
        if (at_top) begin
          wave_nxt = ~lo_bit;
        end else if (match) begin
          wave_nxt = lo_bit;
        end
      end else if (hi_bit && kind == KIND_DUAL) begin
        if (cmp_is_bottom) begin
          wave_nxt = lo_bit;
        end else if (cmp_is_top) begin
          wave_nxt = ~lo_bit;
        end else if (match) begin
          wave_nxt = counting_up ? lo_bit : ~lo_bit;
        end
      end else if (hi_bit && match) begin
        wave_nxt = lo_bit;
      end
    end
  end

  // Pin level register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wave_r <= 1'b0;
    end else begin
      wave_r <= wave_nxt;
    end
  end

  assign compare_output = wave_r;

endmodule : timer16_compare_output

// ==== timer16_waveform_output_control.sv ====
// 16-bit timer with three compare outputs behind an AXI4-Lite register port
//
// The AXI4-Lite interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/10ps
module timer16_waveform_output_control
  import timer16_pkg::*;
#(
  parameter int CHANNELS = 3
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  output logic                   compare_output_a,
  output logic                   compare_output_b,
  output logic                   compare_output_c,
  output logic                   override_a,
  output logic                   override_b,
  output logic                   override_c
);

  // Byte-lane merge for the 16-bit registers
  function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                          input logic [31:0] data,
                                          input logic [3:0]  strb);
    merge16 = {strb[1] ? data[15:8] : old_v[15:8],
               strb[0] ? data[7:0]  : old_v[7:0]};
  endfunction : merge16

  // Byte-lane merge for the 8-bit registers
  function automatic logic [7:0] merge8(input logic [7:0]  old_v,
                                        input logic [31:0] data,
                                        input logic [3:0]  strb);
    merge8 = strb[0] ? data[7:0] : old_v;
  endfunction : merge8

  // Register storage
  logic [7:0]  timer1_waveform_control_a_r;
  logic [7:0]  second_control_register_r;
  logic [15:0] cmp_buf_r [CHANNELS];
  logic [15:0] cmp_act_r [CHANNELS];
  logic [15:0] capture_value_r;

  // Counter state
  logic [15:0] count_r;
  logic [15:0] count_nxt;
  logic        up_r;
  logic        up_nxt;
  logic        overflow_flag_r;
  logic        overflow_flag_nxt;

  // Bus channel state
  logic              aw_hold_r;
  logic [ADDR_W-1:0] aw_addr_r;
  logic              w_hold_r;
  logic [31:0]       w_data_r;
  logic [3:0]        w_strb_r;
  logic              bvalid_r;
  logic [1:0]        bresp_r;
  logic              rvalid_r;
  logic [31:0]       rdata_r;
  logic [1:0]        rresp_r;

  // Mode decode results
  wave_kind_t  kind;
  top_src_t    top_src;
  logic [15:0] fixed_top;
  point_t      update_at;
  point_t      flag_at;

  // Four-bit mode from both control registers
  wire [1:0] waveform_mode_low_bits  = timer1_waveform_control_a_r[WGM_LO_LSB +: 2];
  wire [1:0] waveform_mode_high_bits = second_control_register_r[WGM_HI_LSB +: 2];
  wire [3:0] waveform_mode_select    = {waveform_mode_high_bits, waveform_mode_low_bits};
  wire       run                     = second_control_register_r[RUN_BIT];

  timer16_mode_decode u_decode (
    .waveform_mode_select (waveform_mode_select),
    .kind                 (kind),
    .top_src              (top_src),
    .fixed_top            (fixed_top),
    .update_at            (update_at),
    .flag_at              (flag_at)
  );

  // TOP selection and counter position
  wire [15:0] top_val   = (top_src == TOP_CMPA) ? cmp_act_r[0] :
                          (top_src == TOP_CAPT) ? capture_value_r : fixed_top;
  wire        at_top    = (count_r == top_val);
  wire        at_bottom = (count_r == VAL_BOTTOM);
  wire        at_max    = (count_r == VAL_MAX);
  wire        dual      = (kind == KIND_DUAL);

  // Counting sequence; single slope wraps at TOP, dual slope turns at both ends
  always_comb begin
    up_nxt    = up_r;
    count_nxt = count_r;
    if (run) begin
      if (dual) begin
        up_nxt    = up_r ? !at_top : at_bottom;
        count_nxt = up_nxt ? count_r + 16'h0001 : count_r - 16'h0001;
      end else begin
        up_nxt    = 1'b1;
        count_nxt = at_top ? VAL_BOTTOM : count_r + 16'h0001;
      end
    end
  end

  // Overflow event at the point the mode picks; bottom counts only on the way down
  wire ovf_event = run && ((flag_at == AT_MAX    && at_max) ||
                           (flag_at == AT_TOP    && at_top) ||
                           (flag_at == AT_BOTTOM && at_bottom && !up_r));

  // Compare buffer transfer point; immediate modes follow the buffer every cycle
  wire upd_event = (update_at == AT_IMM) ||
                   (run && update_at == AT_TOP    && at_top) ||
                   (run && update_at == AT_BOTTOM && at_bottom);

  // Write path decode
  wire wr_go      = aw_hold_r && w_hold_r && !bvalid_r;
  wire wr_ctrl_a  = wr_go && (aw_addr_r == OFS_CTRL_A);
  wire wr_ctrl_b  = wr_go && (aw_addr_r == OFS_CTRL_B);
  wire wr_capt    = wr_go && (aw_addr_r == OFS_CAPT);
  wire wr_status  = wr_go && (aw_addr_r == OFS_STATUS);
  wire wr_mapped  = (aw_addr_r == OFS_CTRL_A) || (aw_addr_r == OFS_CTRL_B) ||
                    (aw_addr_r == OFS_CMP_A)  || (aw_addr_r == OFS_CMP_B)  ||
                    (aw_addr_r == OFS_CMP_C)  || (aw_addr_r == OFS_CAPT)   ||
                    (aw_addr_r == OFS_COUNT)  || (aw_addr_r == OFS_STATUS);
  wire ovf_clear  = wr_status && w_strb_r[0] && w_data_r[OVF_BIT];

  // Set wins over a clear that lands in the same cycle
  assign overflow_flag_nxt = ovf_event || (overflow_flag_r && !ovf_clear);

  // Bus handshake outputs
  assign awready = !aw_hold_r && !bvalid_r;
  assign wready  = !w_hold_r && !bvalid_r;
  assign bvalid  = bvalid_r;
  assign bresp   = bresp_r;
  assign arready = !rvalid_r;
  assign rvalid  = rvalid_r;
  assign rdata   = rdata_r;
  assign rresp   = rresp_r;

  // Per-channel compare results and pins
  logic [CHANNELS-1:0] pin_level;
  logic [CHANNELS-1:0] pin_override;

  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch++) begin : g_chan
      wire [1:0] mode_bits = timer1_waveform_control_a_r[MODE_A_LSB - 2*ch +: 2];
      wire       match     = (count_r == cmp_act_r[ch]);
      wire [5:0] cmp_ofs   = OFS_CMP_A + 6'(4*ch);

      timer16_compare_output #(
        .IS_CHANNEL_A (ch == 0)
      ) u_out (
        .aclk           (aclk),
        .aresetn        (aresetn),
        .output_mode    (mode_bits),
        .kind           (kind),
        .wgm3           (waveform_mode_select[3]),
        .tick           (run),
        .match          (match),
        .at_top         (at_top),
        .counting_up    (up_r),
        .cmp_is_top     (cmp_act_r[ch] == top_val),
        .cmp_is_bottom  (cmp_act_r[ch] == VAL_BOTTOM),
        .compare_output (pin_level[ch]),
        .override       (pin_override[ch])
      );

      // Software buffer; write lands here first
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          cmp_buf_r[ch] <= CMP_RESET;
        end else if (wr_go && aw_addr_r == cmp_ofs) begin
          cmp_buf_r[ch] <= merge16(cmp_buf_r[ch], w_data_r, w_strb_r);
        end
      end

      // Active compare value used by the match logic
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          cmp_act_r[ch] <= CMP_RESET;
        end else if (upd_event) begin
          cmp_act_r[ch] <= cmp_buf_r[ch];
        end
      end
    end
  endgenerate

  // Pin direction stays a port matter; these only say what the timer drives
  assign compare_output_a = pin_level[0];
  assign compare_output_b = pin_level[1];
  assign compare_output_c = pin_level[2];
  assign override_a       = pin_override[0];
  assign override_b       = pin_override[1];
  assign override_c       = pin_override[2];

  // Control and capture registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer1_waveform_control_a_r <= CTRL_RESET;
      second_control_register_r   <= CTRL_RESET;
      capture_value_r             <= CMP_RESET;
    end else begin
      if (wr_ctrl_a) begin
        timer1_waveform_control_a_r <= merge8(timer1_waveform_control_a_r, w_data_r, w_strb_r);
      end
      if (wr_ctrl_b) begin
        second_control_register_r <= merge8(second_control_register_r, w_data_r, w_strb_r) & CTRL_B_MASK;
      end
      if (wr_capt) begin
        capture_value_r <= merge16(capture_value_r, w_data_r, w_strb_r);
      end
    end
  end

  // Counter, direction and overflow flag
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_r         <= VAL_BOTTOM;
      up_r            <= 1'b1;
      overflow_flag_r <= 1'b0;
    end else begin
      count_r         <= count_nxt;
      up_r            <= up_nxt;
      overflow_flag_r <= overflow_flag_nxt;
    end
  end

  // Write address and data are taken in either order and held until used
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      aw_addr_r <= '0;
      w_hold_r  <= 1'b0;
      w_data_r  <= '0;
      w_strb_r  <= '0;
    end else begin
      if (awvalid && awready) begin
        aw_hold_r <= 1'b1;
        aw_addr_r <= awaddr;
      end else if (wr_go) begin
        aw_hold_r <= 1'b0;
      end
      if (wvalid && wready) begin
        w_hold_r <= 1'b1;
        w_data_r <= wdata;
        w_strb_r <= wstrb;
      end else if (wr_go) begin
        w_hold_r <= 1'b0;
      end
    end
  end

  // Write response; unmapped offsets answer with a slave error
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r  <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid_r <= 1'b1;
      bresp_r  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // Read data mux; reads have no side effects
  logic [31:0] rd_mux;
  logic        rd_mapped;
  always_comb begin
    rd_mux    = 32'h0000_0000;
    rd_mapped = 1'b1;
    case (araddr)
      OFS_CTRL_A: rd_mux[7:0]  = timer1_waveform_control_a_r;
      OFS_CTRL_B: rd_mux[7:0]  = second_control_register_r;
      OFS_CMP_A:  rd_mux[15:0] = cmp_buf_r[0];
      OFS_CMP_B:  rd_mux[15:0] = cmp_buf_r[1];
      OFS_CMP_C:  rd_mux[15:0] = cmp_buf_r[2];
      OFS_CAPT:   rd_mux[15:0] = capture_value_r;
      OFS_COUNT:  rd_mux[15:0] = count_r;
      OFS_STATUS: begin
        rd_mux[OVF_BIT]           = overflow_flag_r;
        rd_mux[OUT_LSB +: 3]      = pin_level;
        rd_mux[DIR_BIT]           = up_r;
      end
      default:    rd_mapped    = 1'b0;
    endcase
  end

  // Read response register; one read outstanding at a time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid_r <= 1'b1;
      rdata_r  <= rd_mux;
      rresp_r  <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (rready) begin
      rvalid_r <= 1'b0;
    end
  end

endmodule : timer16_waveform_output_control

// ==== timer16_chk.sv ====
// Register port and waveform output checks for the 16-bit timer
`timescale 1ns/10ps
module timer16_chk
  import timer16_pkg::*;
#(parameter int CHANNELS = 3)
(
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic              awvalid,
  input wire logic              awready,
  input wire logic [31:0]       wdata,
  input wire logic [3:0]        wstrb,
  input wire logic              wvalid,
  input wire logic              wready,
  input wire logic [1:0]        bresp,
  input wire logic              bvalid,
  input wire logic              bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic              arvalid,
  input wire logic              arready,
  input wire logic [31:0]       rdata,
  input wire logic [1:0]        rresp,
  input wire logic              rvalid,
  input wire logic              rready,
  input wire logic              compare_output_a,
  input wire logic              compare_output_b,
  input wire logic              compare_output_c,
  input wire logic              override_a,
  input wire logic              override_b,
  input wire logic              override_c
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // One transfer at a time; a pending answer blocks new requests
  write_refused_a: assert property (bvalid |-> !awready && !wready)
    else $error("write accepted while response pending");
  read_refused_a: assert property (rvalid |-> !arready)
    else $error("read accepted while data pending");
  write_answer_a: assert property (awvalid && awready && wvalid && wready |=> !bvalid ##1 bvalid)
    else $error("write response not two edges after handshake");
  read_answer_a: assert property (arvalid && arready |=> rvalid)
    else $error("read data not one edge after handshake");
  resp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped before taken");
  data_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read data changed before taken");
  unmapped_err_a: assert property (arvalid && arready && araddr > OFS_STATUS |=> rresp == RESP_SLVERR && rdata == 32'h0)
    else $error("unmapped read not refused");
  upper_zero_a: assert property (rvalid |-> rdata[31:16] == 16'h0)
    else $error("upper read bits not zero");
  // Pin ownership only moves with a register write, in the cycle its response appears
  override_cause_a: assert property (!$stable({override_a, override_b, override_c}) |-> $rose(bvalid))
    else $error("override changed without a write");
  status_out_a: assert property (arvalid && arready && araddr == OFS_STATUS
    |=> rdata[3:1] == $past({compare_output_c, compare_output_b, compare_output_a}))
    else $error("status does not mirror compare outputs");
endmodule : timer16_chk

bind timer16_waveform_output_control timer16_chk #(.CHANNELS(CHANNELS)) chk (
  .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
  .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
  .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
  .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
  .compare_output_a(compare_output_a), .compare_output_b(compare_output_b),
  .compare_output_c(compare_output_c), .override_a(override_a), .override_b(override_b),
  .override_c(override_c));

// ==== pin_pads.sv ====
// Port pads fed by the compare outputs, pulled up when not driven
`timescale 1ns/10ps
module pin_pads (
  input  wire logic [2:0] cmp_out,
  input  wire logic [2:0] ovr,
  input  wire logic [2:0] dir_out,
  input  wire logic [2:0] port_val,
  output logic      [2:0] pin
);
  // Without the direction bit the compare output never reaches the pad
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      if (!dir_out[i]) pin[i] = 1'b1;
      else if (ovr[i]) pin[i] = cmp_out[i];
      else pin[i] = port_val[i];
    end
  end
endmodule : pin_pads

// ==== testbench.sv ====
// Self-checking bench for the waveform timer: registers, modes and duty
`timescale 1ns/10ps
module testbench;
  import timer16_pkg::*;
  logic        aclk = 0, aresetn = 0;
  logic [5:0]  awaddr = '0, araddr = '0;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = '0, rdata;
  logic [3:0]  wstrb = 4'hf;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  wire  [2:0]  outs, ovr, pin;
  logic [2:0]  dir_out = 3'b111, port_val = 3'b000;
  logic [15:0] cmpb;
  int          n_fail = 0, n_compared = 0;
  int          modes[14] = '{1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 12, 14, 15};
  always #50 aclk = ~aclk;
  timer16_waveform_output_control dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .compare_output_a(outs[0]), .compare_output_b(outs[1]),
    .compare_output_c(outs[2]), .override_a(ovr[0]), .override_b(ovr[1]), .override_c(ovr[2]));
  pin_pads pads (.cmp_out(outs), .ovr(ovr), .dir_out(dir_out), .port_val(port_val), .pin(pin));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic give_verdict;
    $display("compared %0d, mismatched %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict
  // Handshakes are judged at the falling edge, where nothing is moving
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    bit ta, tw, done;
    int k;
    k = $urandom % 3;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= (k == 0);
    for (int n = 0; n < 50 && !done; n++) begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      done = bvalid && bready;
      @(posedge aclk);
      if (ta) awvalid <= 0;
      if (tw) wvalid <= 0;
      if (done) bready <= 0;
      else if (n + 1 >= k) bready <= 1;
    end
    if (!done) n_fail++;
  endtask : wr
  task automatic rd(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
    bit ta, done;
    int k;
    k = $urandom % 3;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    rready <= (k == 0);
    for (int n = 0; n < 50 && !done; n++) begin
      @(negedge aclk);
      ta = arvalid && arready;
      done = rvalid && rready;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 0;
      if (done) rready <= 0;
      else if (n + 1 >= k) rready <= 1;
    end
    if (!done) n_fail++;
  endtask : rd
  task automatic do_reset;
    @(posedge aclk);
    aresetn <= 0;
    repeat (8) @(posedge aclk);
    aresetn <= 1;
  endtask : do_reset
  // Reset first so a counter above the new TOP cannot run to the full range
  task automatic setup(input logic [3:0] m, input logic [1:0] om, input logic [15:0] cb);
    do_reset();
    wr(OFS_CMP_A, 32'h50);
    wr(OFS_CMP_B, {16'h0, cb});
    wr(OFS_CAPT, 32'h60);
    wr(OFS_CTRL_A, {24'h0, 2'b00, om, 2'b00, m[1:0]});
    wr(OFS_CTRL_B, {27'h0, m[3:2], 3'b001});
  endtask : setup
  // Steady-state period and high time of one output, skipping the first cycle
  task automatic meas(input int ch, output int per, output int hi);
    int r[$];
    int f;
    logic p;
    f = -1;
    p = outs[ch];
    for (int n = 0; n < 9000 && r.size() < 3; n++) begin
      @(negedge aclk);
      if (outs[ch] && !p) r.push_back(n);
      if (!outs[ch] && p && r.size() == 2 && f < 0) f = n;
      p = outs[ch];
    end
    per = (r.size() == 3) ? r[2] - r[1] : -1;
    hi = (r.size() == 3) ? f - r[1] : -1;
  endtask : meas
  task automatic steady(input int ch, input logic lvl);
    int bad;
    bad = 0;
    repeat (300) @(posedge aclk);
    for (int n = 0; n < 600; n++) begin
      @(negedge aclk);
      if (outs[ch] !== lvl) bad++;
    end
    check(32'(bad), 32'h0);
  endtask : steady
  function automatic void expect_wave(input int m, output int per, output int hi);
    int top;
    case (m)
      1, 5: top = 'hff;
      2, 6: top = 'h1ff;
      3, 7: top = 'h3ff;
      8, 10, 12, 14: top = 'h60;
      default: top = 'h50;
    endcase
    if (m == 4 || m == 12) begin
      per = 2 * (top + 1);
      hi = top + 1;
    end else if ((m >= 5 && m <= 7) || m >= 14) begin
      per = top + 1;
      hi = cmpb + 1;
    end else begin
      per = 2 * top;
      hi = 2 * cmpb;
    end
  endfunction : expect_wave
  initial begin
    repeat (60000) @(posedge aclk);
    n_fail++;
    give_verdict();
  end
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    logic [7:0] v;
    int gp, gh, ep, eh;
    void'($urandom(32'h5daf));
    do_reset();
    rd(OFS_CTRL_A, d, r);
    check(d, 32'h0);
    rd(6'h20, d, r);
    check(32'(r), 32'(RESP_SLVERR));
    // Random channel modes in normal mode: readback and pin ownership
    for (int i = 0; i < 10; i++) begin
      v = 8'($urandom) & 8'hfc;
      port_val <= 3'($urandom);
      wr(OFS_CTRL_A, {24'h0, v});
      rd(OFS_CTRL_A, d, r);
      check(d, {24'h0, v});
      @(negedge aclk);
      check(32'(ovr), 32'({|v[3:2], |v[5:4], |v[7:6]}));
      check(32'(pin), 32'(port_val & ~{|v[3:2], |v[5:4], |v[7:6]}));
    end
    dir_out <= 3'b000;
    @(negedge aclk);
    check(32'(pin), 32'h7);
    dir_out <= 3'b111;
    wr(OFS_CTRL_B, 32'h08);
    wr(OFS_CTRL_A, 32'h55);
    @(negedge aclk);
    check(32'(ovr), 32'h0);
    // Mode bits first so the counter starts from zero with TOP at zero
    wr(OFS_CTRL_A, 32'h57);
    wr(OFS_CTRL_B, 32'hff);
    @(negedge aclk);
    check(32'(ovr), 32'h1);
    v[0] = outs[0];
    @(negedge aclk);
    check(32'(outs[0]), 32'(!v[0]));
    rd(OFS_CTRL_B, d, r);
    check(d, {24'h0, CTRL_B_MASK});
    foreach (modes[i]) begin
      cmpb = 16'h8 + 16'($urandom % 64);
      setup(modes[i][3:0], (modes[i] == 4 || modes[i] == 12) ? 2'b01 : 2'b10, cmpb);
      expect_wave(modes[i], ep, eh);
      meas(1, gp, gh);
      check(32'(gp), 32'(ep));
      check(32'(gh), 32'(eh));
    end
    setup(5, 2'b11, 16'h20);
    meas(1, gp, gh);
    check(32'(gh), 32'hdf);
    setup(1, 2'b11, 16'h20);
    meas(1, gp, gh);
    check(32'(gh), 32'h1be);
    setup(5, 2'b10, 16'hff);
    steady(1, 1'b1);
    setup(1, 2'b10, 16'h0);
    steady(1, 1'b0);
    setup(1, 2'b11, 16'hff);
    steady(1, 1'b0);
    setup(4, 2'b11, 16'h10);
    steady(1, 1'b1);
    steady(2, 1'b0);
    give_verdict();
  end
endmodule : testbench
